// ===== hdl/repeater_cfg.svh
// Purpose: Named constants for the repeater serial configuration block.
// Assumes: Included by bare name; definitions only.
// Notes: Command codes are upper or lower nibbles as noted.
`ifndef REPEATER_CFG_SVH
`define REPEATER_CFG_SVH

`define CLK_PERIOD_NS 20
`define BIT_TIME_NS 100
`define SQE_WIN_LO_BT 6
`define SQE_WIN_HI_BT 34
`define BLINK_SLOW_MS 512
`define BLINK_LONG_MS 1560
`define SQE_CNT_W 8

`define NIB_OPTION 4'h0
`define NIB_ALT_PART 4'h1
`define NIB_PORT_OFF 4'h2
`define NIB_PORT_ON 4'h3
`define NIB_LINK_OFF 4'h4
`define NIB_LINK_ON 4'h5
`define NIB_POL_OFF 4'h6
`define NIB_POL_ON 4'h7
`define NIB_LED_CLEAR 4'h9
`define NIB_LED_BANK_A 4'hb
`define NIB_LED_BANK_B 4'hc
`define NIB_BLINK 4'he

`define LOW_AUI 4'hf
`define LOW_TP_ALL 4'h0
`define LOW_OPTION_MASK 4'hd
`define LOW_OPTION_VAL 4'h8
`define OPTION_S_BIT 1
`define SUB_SEL_BIT 3
`define BLINK_SEL_MASK 4'hc
`define BLINK_SEL_VAL 4'h8

`define SEL_AUI 4'h8
`define SEL_TP_ALL 4'hb
`define SEL_ALL_PORTS 4'hc
`define SEL_GLOBAL 4'hd

`define LED_AUI_IDX 4
`define LED_GLOBAL_IDX 5

`endif

// ===== hdl/repeater_pkg.sv
// Purpose: Types shared by the serial configuration block.
// Assumes: Constants live in repeater_cfg.svh.
// Notes: Receiver result crosses domains as one struct.
package repeater_pkg;

  typedef enum logic [1:0] {
    BLINK_OFF,
    BLINK_SLOW,
    BLINK_LONG,
    BLINK_SOLID
  } blink_rate_t;

  typedef enum logic {
    RX_IDLE,
    RX_DATA
  } rx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic done_toggle;
  } rx_word_t;

  typedef struct packed {
    logic [5:0] bank_a;
    logic [5:0] bank_b;
  } led_override_t;

endpackage : repeater_pkg

// ===== hdl/serial_cmd_rx.sv
// Purpose: Serial command receiver on the controller's own clock.
// Assumes: Command input is set up and held around rising serial clock edges.
// Notes: Completed byte is held until the next byte completes.
`timescale 1ns/1ps
`default_nettype none

module serial_cmd_rx
  import repeater_pkg::*;
(
  input wire logic serial_clk_in,
  input wire logic rst_in,
  input wire logic serial_in,
  output rx_word_t rx_out
);

  logic rst_meta;
  logic rst_sync;
  rx_state_t state;
  logic [2:0] bit_cnt;
  logic [6:0] shift;

  // Reset from the system domain enters through two flops
  always_ff @(posedge serial_clk_in) begin
    rst_meta <= rst_in;
    rst_sync <= rst_meta;
  end

  always_ff @(posedge serial_clk_in) begin
    if (rst_sync) begin
      state <= RX_IDLE;
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      rx_out <= '0;
    end else begin
      unique case (state)
        RX_IDLE: begin
          if (!serial_in) begin
            state <= RX_DATA;
            bit_cnt <= 3'h0;
          end
        end
        RX_DATA: begin
          shift <= {serial_in, shift[6:1]};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            rx_out.data <= {serial_in, shift};
            rx_out.done_toggle <= ~rx_out.done_toggle;
            state <= RX_IDLE;
          end
        end
      endcase
    end
  end

endmodule : serial_cmd_rx

`default_nettype wire

// ===== hdl/repeater_cfg_ctrl.sv
// Purpose: Decodes set commands from the serial control port into configuration.
// Assumes: Serial clock is unrelated to clk_in and may stop between bytes.
// Notes: Status inputs come from repeater logic on clk_in; pins are synchronised.
`timescale 1ns/1ps
`default_nettype none

`include "repeater_cfg.svh"

// Summary of operation
// - Command is start bit plus eight data bits, LSB first, on serial clock rise.
// - Byte 0000 10S0 loads the collision window mask from bit S.
// - With mask set, ignore collision pair between 6 and 34 bit times after AUI send.
// - Masking does not stop reporting of the window event.
// - Collision pair activity outside the window is a real collision while AUI is enabled.
// - 0001 1111 sets AUI transmit-only reconnection; only reset restores standard.
// - 0001 0000 sets TP transmit-only reconnection; only reset restores standard.
// - 0010 1111 disables AUI, 0011 1111 enables; disabled port is idle and ignored.
// - 0010 00## disables a TP port; its partition logic goes idle.
// - 0011 00## enables the TP port given by low two bits.
// - 0100 00## turns off link checking; link then reads passing.
// - 0101 00## turns on link checking; failing enabled port is disconnected.
// - 0100 10## stops, 0101 10## resumes link pulses on a TP port.
// - 0110 00## turns off polarity correction; reversed port then fails link.
// - Command input level at reset release sets polarity correction default.
// - 0111 00## enables polarity correction; reversed receiver is inverted.
// - 0111 10## lowers squelch, 0110 10## restores normal; normal after reset.
// - Low nibble picks LED target: TP0-3, AUI, all TP, all ports, global.
// - 1001 #### cancels LED override; pin-selected attributes show again.
// - 1011 #### makes bank A LEDs blink at the last blink rate.
// - 1100 #### makes bank B LEDs blink at the last blink rate.
// - After reset no LED is overridden.
// - 1110 10xx sets shared blink: off, 512 ms, 1560 ms, solid on.
module repeater_cfg_ctrl
  import repeater_pkg::*;
#(
  parameter int PORTS = 4,
  parameter int HALF_SLOW_CYC = (`BLINK_SLOW_MS * 1000000 / `CLK_PERIOD_NS) / 2,
  parameter int HALF_LONG_CYC = (`BLINK_LONG_MS * 1000000 / `CLK_PERIOD_NS) / 2,
  parameter int BLINK_W = 26
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic serial_clk_in,
  input wire logic serial_in,
  input wire logic aui_tx_active_in,
  input wire logic collision_presence_pair_in,
  input wire logic [PORTS-1:0] link_pass_in,
  input wire logic [PORTS-1:0] polarity_reversed_in,
  input wire logic [5:0] led_attr_a_in,
  input wire logic [5:0] led_attr_b_in,
  output logic sqe_mask_out,
  output logic aui_alt_partition_out,
  output logic tp_alt_partition_out,
  output logic aui_enable_out,
  output logic [PORTS-1:0] tp_enable_out,
  output logic [PORTS-1:0] link_test_enable_out,
  output logic [PORTS-1:0] link_pulse_enable_out,
  output logic [PORTS-1:0] polarity_correct_enable_out,
  output logic [PORTS-1:0] extended_distance_out,
  output logic aui_collision_out,
  output logic sqe_window_activity_out,
  output logic [PORTS-1:0] link_status_out,
  output logic [PORTS-1:0] link_fail_disconnect_out,
  output logic [PORTS-1:0] rx_invert_out,
  output logic [1:0] blink_rate_out,
  output logic [5:0] led_a_on_out,
  output logic [5:0] led_b_on_out
);

  localparam int WIN_LO_CYC = (`SQE_WIN_LO_BT * `BIT_TIME_NS + `CLK_PERIOD_NS - 1)
                              / `CLK_PERIOD_NS;
  localparam int WIN_HI_CYC = (`SQE_WIN_HI_BT * `BIT_TIME_NS) / `CLK_PERIOD_NS;
  localparam logic [`SQE_CNT_W-1:0] WIN_LO = WIN_LO_CYC[`SQE_CNT_W-1:0];
  localparam logic [`SQE_CNT_W-1:0] WIN_HI = WIN_HI_CYC[`SQE_CNT_W-1:0];
  localparam logic [BLINK_W-1:0] HALF_SLOW = HALF_SLOW_CYC[BLINK_W-1:0];
  localparam logic [BLINK_W-1:0] HALF_LONG = HALF_LONG_CYC[BLINK_W-1:0];

  rx_word_t rx_word;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic cmd_valid;
  logic [7:0] cmd;
  logic si_meta;
  logic si_sync;
  logic rst_prev;
  logic col_meta;
  logic col_sync;
  logic tx_prev;
  logic sqe_counting;
  logic [`SQE_CNT_W-1:0] sqe_cnt;
  logic in_window;
  led_override_t led_ovr;
  blink_rate_t blink_rate;
  logic [BLINK_W-1:0] blink_cnt;
  logic blink_phase;
  logic [3:0] hi_nib;
  logic [3:0] lo_nib;
  logic [1:0] port_idx;
  logic [5:0] target;
  logic tp_cmd;

  serial_cmd_rx rx_inst (
    .serial_clk_in(serial_clk_in),
    .rst_in(rst_in),
    .serial_in(serial_in),
    .rx_out(rx_word)
  );

  // Byte-done toggle crosses by two flops; data is stable for nine serial edges
  always_ff @(posedge clk_in) begin
    tog_meta <= rx_word.done_toggle;
    tog_sync <= tog_meta;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tog_seen <= 1'b0;
      cmd_valid <= 1'b0;
      cmd <= 8'h00;
    end else begin
      tog_seen <= tog_sync;
      cmd_valid <= tog_sync ^ tog_seen;
      if (tog_sync ^ tog_seen) begin
        cmd <= rx_word.data;
      end
    end
  end

  // Command input and collision pair are pins: two flops before use
  always_ff @(posedge clk_in) begin
    si_meta <= serial_in;
    si_sync <= si_meta;
    col_meta <= collision_presence_pair_in;
    col_sync <= col_meta;
    rst_prev <= rst_in;
  end

  assign hi_nib = cmd[7:4];
  assign lo_nib = cmd[3:0];
  assign port_idx = cmd[1:0];
  // Per-port TP commands need bits 3..2 clear, or 10 for the second group
  assign tp_cmd = (cmd[2] == 1'b0);

  always_comb begin
    target = 6'h00;
    if (lo_nib[3:2] == 2'b00) begin
      target[lo_nib[1:0]] = 1'b1;
    end else if (lo_nib == `SEL_AUI) begin
      target[`LED_AUI_IDX] = 1'b1;
    end else if (lo_nib == `SEL_TP_ALL) begin
      target[PORTS-1:0] = '1;
    end else if (lo_nib == `SEL_ALL_PORTS) begin
      target[`LED_AUI_IDX:0] = '1;
    end else if (lo_nib == `SEL_GLOBAL) begin
      target[`LED_GLOBAL_IDX] = 1'b1;
    end
  end

  // Chip option and partition algorithm selection
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sqe_mask_out <= 1'b0;
      aui_alt_partition_out <= 1'b0;
      tp_alt_partition_out <= 1'b0;
    end else if (cmd_valid) begin
      if (hi_nib == `NIB_OPTION && (lo_nib & `LOW_OPTION_MASK) == `LOW_OPTION_VAL) begin
        sqe_mask_out <= cmd[`OPTION_S_BIT];
      end
      if (hi_nib == `NIB_ALT_PART && lo_nib == `LOW_AUI) begin
        aui_alt_partition_out <= 1'b1;
      end
      if (hi_nib == `NIB_ALT_PART && lo_nib == `LOW_TP_ALL) begin
        tp_alt_partition_out <= 1'b1;
      end
    end
  end

  // Port enables; a disabled port holds its partition logic idle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aui_enable_out <= 1'b1;
      tp_enable_out <= '1;
    end else if (cmd_valid) begin
      if (hi_nib == `NIB_PORT_OFF && lo_nib == `LOW_AUI) begin
        aui_enable_out <= 1'b0;
      end
      if (hi_nib == `NIB_PORT_ON && lo_nib == `LOW_AUI) begin
        aui_enable_out <= 1'b1;
      end
      if (hi_nib == `NIB_PORT_OFF && lo_nib[3:2] == 2'b00) begin
        tp_enable_out[port_idx] <= 1'b0;
      end
      if (hi_nib == `NIB_PORT_ON && lo_nib[3:2] == 2'b00) begin
        tp_enable_out[port_idx] <= 1'b1;
      end
    end
  end

  // Link test and link pulse controls
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      link_test_enable_out <= '1;
      link_pulse_enable_out <= '1;
    end else if (cmd_valid && lo_nib[2] == 1'b0 && tp_cmd) begin
      if (hi_nib == `NIB_LINK_OFF || hi_nib == `NIB_LINK_ON) begin
        if (!cmd[`SUB_SEL_BIT]) begin
          link_test_enable_out[port_idx] <= (hi_nib == `NIB_LINK_ON);
        end else begin
          link_pulse_enable_out[port_idx] <= (hi_nib == `NIB_LINK_ON);
        end
      end
    end
  end

  // Polarity correction takes the strap in the cycle after reset release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      polarity_correct_enable_out <= '1;
      extended_distance_out <= '0;
    end else if (rst_prev) begin
      polarity_correct_enable_out <= {PORTS{~si_sync}};
    end else if (cmd_valid && lo_nib[2] == 1'b0) begin
      if (hi_nib == `NIB_POL_OFF || hi_nib == `NIB_POL_ON) begin
        if (!cmd[`SUB_SEL_BIT]) begin
          polarity_correct_enable_out[port_idx] <= (hi_nib == `NIB_POL_ON);
        end else begin
          extended_distance_out[port_idx] <= (hi_nib == `NIB_POL_ON);
        end
      end
    end
  end

  // LED override state and blink rate; reserved selectors give an empty target
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      led_ovr <= '0;
      blink_rate <= BLINK_OFF;
    end else if (cmd_valid) begin
      unique case (hi_nib)
        `NIB_LED_CLEAR: begin
          led_ovr.bank_a <= led_ovr.bank_a & ~target;
          led_ovr.bank_b <= led_ovr.bank_b & ~target;
        end
        `NIB_LED_BANK_A: begin
          led_ovr.bank_a <= led_ovr.bank_a | target;
        end
        `NIB_LED_BANK_B: begin
          led_ovr.bank_b <= led_ovr.bank_b | target;
        end
        `NIB_BLINK: begin
          if ((lo_nib & `BLINK_SEL_MASK) == `BLINK_SEL_VAL) begin
            blink_rate <= blink_rate_t'(lo_nib[1:0]);
          end
        end
        default: begin
          blink_rate <= blink_rate;
        end
      endcase
    end
  end

  // Shared blink timer; held at zero while off or solid, not restarted on a slow/long change
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else if (blink_rate == BLINK_OFF || blink_rate == BLINK_SOLID) begin
      blink_cnt <= '0;
      blink_phase <= (blink_rate == BLINK_SOLID);
    end else if (blink_cnt >= ((blink_rate == BLINK_SLOW ? HALF_SLOW : HALF_LONG)
                               - BLINK_W'(1))) begin
      blink_cnt <= '0;
      blink_phase <= ~blink_phase;
    end else begin
      blink_cnt <= blink_cnt + BLINK_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      blink_rate_out <= 2'b00;
    end else begin
      blink_rate_out <= blink_rate;
    end
  end

  genvar led;
  generate
    for (led = 0; led < 6; led++) begin : g_led
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          led_a_on_out[led] <= 1'b0;
          led_b_on_out[led] <= 1'b0;
        end else begin
          led_a_on_out[led] <= led_ovr.bank_a[led] ? blink_phase : led_attr_a_in[led];
          led_b_on_out[led] <= led_ovr.bank_b[led] ? blink_phase : led_attr_b_in[led];
        end
      end
    end
  endgenerate

  // Window timer starts at the end of each AUI transmission
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_prev <= 1'b0;
      sqe_counting <= 1'b0;
      sqe_cnt <= '0;
    end else begin
      tx_prev <= aui_tx_active_in;
      if (aui_tx_active_in) begin
        sqe_counting <= 1'b0;
        sqe_cnt <= '0;
      end else if (tx_prev) begin
        sqe_counting <= 1'b1;
        sqe_cnt <= '0;
      end else if (sqe_counting) begin
        sqe_cnt <= sqe_cnt + `SQE_CNT_W'(1);
        if (sqe_cnt >= WIN_HI) begin
          sqe_counting <= 1'b0;
        end
      end
    end
  end

  assign in_window = sqe_counting && sqe_cnt >= WIN_LO && sqe_cnt <= WIN_HI;

  // Masking and reporting are separate paths; disabled AUI ignores the pair
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aui_collision_out <= 1'b0;
      sqe_window_activity_out <= 1'b0;
    end else begin
      aui_collision_out <= aui_enable_out && col_sync
                           && !(sqe_mask_out && in_window);
      sqe_window_activity_out <= aui_enable_out && col_sync && in_window;
    end
  end

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      logic link_ok;
      // Uncorrected reversed polarity inverts link pulses, so the link fails
      assign link_ok = link_pass_in[p]
                       && (!polarity_reversed_in[p] || polarity_correct_enable_out[p]);
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          link_status_out[p] <= 1'b0;
          link_fail_disconnect_out[p] <= 1'b0;
          rx_invert_out[p] <= 1'b0;
        end else begin
          link_status_out[p] <= link_ok || !link_test_enable_out[p];
          link_fail_disconnect_out[p] <= !link_ok && link_test_enable_out[p]
                                         && tp_enable_out[p];
          rx_invert_out[p] <= polarity_reversed_in[p]
                              && polarity_correct_enable_out[p];
        end
      end
    end
  endgenerate

endmodule : repeater_cfg_ctrl

`default_nettype wire

// ===== testbench/repeater_cfg_ctrl_props.sv
// Purpose: Port-level checks for the serial configuration block.
// Assumes: One clk_in domain; derived status lags its cause by up to three cycles.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module repeater_cfg_ctrl_props #(
  parameter int PORTS = 4
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic collision_presence_pair_in,
  input wire logic [5:0] led_attr_a_in,
  input wire logic sqe_mask_out,
  input wire logic aui_alt_partition_out,
  input wire logic tp_alt_partition_out,
  input wire logic aui_enable_out,
  input wire logic [PORTS-1:0] tp_enable_out,
  input wire logic [PORTS-1:0] link_test_enable_out,
  input wire logic [PORTS-1:0] polarity_correct_enable_out,
  input wire logic aui_collision_out,
  input wire logic [PORTS-1:0] link_status_out,
  input wire logic [PORTS-1:0] link_fail_disconnect_out,
  input wire logic [PORTS-1:0] rx_invert_out,
  input wire logic [1:0] blink_rate_out,
  input wire logic [5:0] led_a_on_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Pair held four samples covers the two sync flops plus the output register
  chk_collision_true:
    assert property ((!sqe_mask_out && aui_enable_out && collision_presence_pair_in)[*4]
      |-> aui_collision_out) else $error("unmasked collision not reported");
  chk_disabled_quiet:
    assert property ((!aui_enable_out)[*3] |-> !aui_collision_out)
      else $error("collision on disabled port");
  chk_link_pass_shown:
    assert property ((~link_test_enable_out & ~$past(link_test_enable_out)
      & ~link_status_out) == '0) else $error("link not passing with test off");
  chk_disconnect_cause:
    assert property ((link_fail_disconnect_out & ~((link_test_enable_out & tp_enable_out)
      | $past(link_test_enable_out & tp_enable_out))) == '0)
      else $error("disconnect without test and port enabled");
  chk_invert_cause:
    assert property ((rx_invert_out & ~(polarity_correct_enable_out
      | $past(polarity_correct_enable_out))) == '0) else $error("invert while correction off");
  chk_aui_alt_sticky:
    assert property (aui_alt_partition_out |=> aui_alt_partition_out)
      else $error("aui alternate reconnection dropped");
  chk_tp_alt_sticky:
    assert property (tp_alt_partition_out |=> tp_alt_partition_out)
      else $error("tp alternate reconnection dropped");
  chk_blink_off_dark:
    assert property ((blink_rate_out == 2'h0)[*3] |-> (led_a_on_out & ~($past(led_attr_a_in)
      | $past(led_attr_a_in, 2) | $past(led_attr_a_in, 3))) == 6'h00)
      else $error("led lit with blink off");
endmodule : repeater_cfg_ctrl_props
bind repeater_cfg_ctrl repeater_cfg_ctrl_props #(.PORTS(PORTS)) props_u (.clk_in, .rst_in,
  .collision_presence_pair_in, .led_attr_a_in, .sqe_mask_out, .aui_alt_partition_out,
  .tp_alt_partition_out, .aui_enable_out, .tp_enable_out, .link_test_enable_out,
  .polarity_correct_enable_out, .aui_collision_out, .link_status_out,
  .link_fail_disconnect_out, .rx_invert_out, .blink_rate_out, .led_a_on_out);
`default_nettype wire

// ===== testbench/repeater_serial_host.sv
// Purpose: Controller model driving the serial command line and its clock.
// Assumes: Data changes on falling clock, sampled on the rising edge.
// Notes: Clock stands still between frames; the line idles high.
`timescale 1ns/1ps
`default_nettype none
module repeater_serial_host (
  output logic serial_clk_out,
  output logic serial_out
);
  initial begin
    serial_clk_out = 1'b0;
    serial_out = 1'b1;
  end
  task automatic set_line(input logic v);
    serial_out = v;
  endtask : set_line
  task automatic tick(input int n);
    repeat (n) begin
      #6 serial_clk_out = 1'b1;
      #6 serial_clk_out = 1'b0;
    end
  endtask : tick
  task automatic send_byte(input logic [7:0] b);
    logic [8:0] frame;
    frame = {b, 1'b0};
    for (int i = 0; i < 9; i++) begin
      serial_out = frame[i];
      tick(1);
    end
    #6 serial_out = 1'b1;
    #6;
  endtask : send_byte
endmodule : repeater_serial_host
`default_nettype wire

// ===== testbench/repeater_serial_config_commands_bench.sv
// Purpose: Self-checking bench for the serial configuration block.
// Assumes: Blink half periods shortened to 8 and 20 cycles.
// Notes: Expected state is kept in a small model fed by every byte sent.
`timescale 1ns/1ps
`default_nettype none
module repeater_serial_config_commands_bench;
  import repeater_pkg::*;
  localparam int HS = 8;
  localparam int HL = 20;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic serial_clk_in, serial_in;
  logic aui_tx_active_in = 1'b0;
  logic collision_presence_pair_in = 1'b0;
  logic [3:0] link_pass_in = 4'hf;
  logic [3:0] polarity_reversed_in = 4'h0;
  logic [5:0] led_attr_a_in = 6'h00;
  logic [5:0] led_attr_b_in = 6'h00;
  logic sqe_mask_out, aui_alt_partition_out, tp_alt_partition_out, aui_enable_out;
  logic aui_collision_out, sqe_window_activity_out;
  logic [3:0] tp_enable_out, link_test_enable_out, link_pulse_enable_out;
  logic [3:0] polarity_correct_enable_out, extended_distance_out;
  logic [3:0] link_status_out, link_fail_disconnect_out, rx_invert_out;
  logic [1:0] blink_rate_out;
  logic [5:0] led_a_on_out, led_b_on_out;
  logic e_mask, e_aalt, e_talt, e_aen;
  logic [3:0] e_ten, e_lt, e_lp, e_pce, e_ext;
  logic [1:0] e_blink;
  int err_total = 0;
  int checks_done = 0;
  always #10 clk_in = ~clk_in;
  repeater_serial_host host_u (.serial_clk_out(serial_clk_in), .serial_out(serial_in));
  repeater_cfg_ctrl #(.HALF_SLOW_CYC(HS), .HALF_LONG_CYC(HL)) dut_u (.clk_in, .rst_in,
    .serial_clk_in, .serial_in, .aui_tx_active_in, .collision_presence_pair_in,
    .link_pass_in, .polarity_reversed_in, .led_attr_a_in, .led_attr_b_in, .sqe_mask_out,
    .aui_alt_partition_out, .tp_alt_partition_out, .aui_enable_out, .tp_enable_out,
    .link_test_enable_out, .link_pulse_enable_out, .polarity_correct_enable_out,
    .extended_distance_out, .aui_collision_out, .sqe_window_activity_out, .link_status_out,
    .link_fail_disconnect_out, .rx_invert_out, .blink_rate_out, .led_a_on_out,
    .led_b_on_out);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic settle();
    repeat (8) @(posedge clk_in);
  endtask : settle
  task automatic send(input logic [7:0] b);
    host_u.send_byte(b);
    case (b[7:4])
      4'h0: if ((b[3:0] & 4'hd) == 4'h8) e_mask = b[1];
      4'h1: begin
        if (b[3:0] == 4'hf) e_aalt = 1'b1;
        else if (b[3:0] == 4'h0) e_talt = 1'b1;
      end
      4'h2, 4'h3: begin
        if (b[3:0] == 4'hf) e_aen = b[4];
        else if (b[3:2] == 2'b00) e_ten[b[1:0]] = b[4];
      end
      4'h4, 4'h5: begin
        if (b[3:2] == 2'b00) e_lt[b[1:0]] = b[4];
        else if (b[3:2] == 2'b10) e_lp[b[1:0]] = b[4];
      end
      4'h6, 4'h7: begin
        if (b[3:2] == 2'b00) e_pce[b[1:0]] = b[4];
        else if (b[3:2] == 2'b10) e_ext[b[1:0]] = b[4];
      end
      4'he: if (b[3:2] == 2'b10) e_blink = b[1:0];
      default: ;
    endcase
  endtask : send
  task automatic check_cfg();
    check("sqe_mask", sqe_mask_out, e_mask);
    check("aui_alt", aui_alt_partition_out, e_aalt);
    check("tp_alt", tp_alt_partition_out, e_talt);
    check("aui_en", aui_enable_out, e_aen);
    check("tp_en", tp_enable_out, e_ten);
    check("link_test", link_test_enable_out, e_lt);
    check("link_pulse", link_pulse_enable_out, e_lp);
    check("polarity", polarity_correct_enable_out, e_pce);
    check("squelch", extended_distance_out, e_ext);
    check("blink", blink_rate_out, e_blink);
  endtask : check_cfg
  task automatic do_reset(input logic strap);
    @(negedge clk_in);
    host_u.set_line(strap);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    // Receiver reset only clears on serial clock edges
    host_u.tick(4);
    @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    host_u.set_line(1'b1);
    host_u.tick(4);
    settle();
    {e_mask, e_aalt, e_talt, e_ext, e_blink} = '0;
    {e_aen, e_ten, e_lt, e_lp} = '1;
    e_pce = {4{~strap}};
    check_cfg();
    check("led_a", led_a_on_out, led_attr_a_in);
    check("led_b", led_b_on_out, led_attr_b_in);
    $display("reset done");
  endtask : do_reset
  task automatic test_commands();
    logic [7:0] seq [$];
    logic [7:0] ops [$];
    seq = '{8'h0a, 8'h0c, 8'h08, 8'h0a, 8'h2f, 8'hff, 8'h80, 8'he0, 8'hec, 8'h3f, 8'h1f, 8'h10};
    ops = '{8'h20, 8'h40, 8'h48, 8'h60, 8'h78, 8'h30, 8'h50, 8'h58, 8'h70, 8'h68};
    foreach (seq[i]) begin
      send(seq[i]);
      settle();
      check_cfg();
    end
    for (int p = 0; p < 4; p++) begin
      foreach (ops[k]) begin
        send(ops[k] | 8'(p));
        // Odd steps go back to back with the previous byte
        if (k % 2 == 1) begin
          settle();
          check_cfg();
        end
      end
    end
    $display("commands done");
  endtask : test_commands
  task automatic col_run(input logic [7:0] c, input int start, input logic ec, input logic ew);
    logic col, win;
    send(c);
    settle();
    col = 1'b0;
    win = 1'b0;
    aui_tx_active_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    aui_tx_active_in <= 1'b0;
    for (int t = 0; t < start + 40; t++) begin
      @(negedge clk_in);
      col |= aui_collision_out;
      win |= sqe_window_activity_out;
      @(posedge clk_in);
      collision_presence_pair_in <= (t >= start && t < start + 20);
    end
    check("collision", col, ec);
    if (ew !== 1'bx) check("window", win, ew);
  endtask : col_run
  task automatic test_collision();
    col_run(8'h0a, 100, 1'b0, 1'b1);
    col_run(8'h08, 100, 1'b1, 1'b1);
    col_run(8'h0a, 250, 1'b1, 1'b0);
    col_run(8'h2f, 250, 1'b0, 1'b0);
    send(8'h3f);
    $display("collision done");
  endtask : test_collision
  task automatic test_link();
    link_pass_in <= 4'h0;
    send(8'h41);
    settle();
    check("status", link_status_out, 4'h2);
    check("disconnect", link_fail_disconnect_out, 4'hd);
    send(8'h22);
    settle();
    check("disconnect", link_fail_disconnect_out, 4'h9);
    link_pass_in <= 4'hf;
    polarity_reversed_in <= 4'h1;
    send(8'h32);
    settle();
    check("invert", rx_invert_out, 4'h1);
    check("status", link_status_out, 4'hf);
    send(8'h60);
    settle();
    check("invert", rx_invert_out, 4'h0);
    check("status", link_status_out, 4'he);
    check("disconnect", link_fail_disconnect_out, 4'h1);
    $display("link done");
  endtask : test_link
  task automatic test_led();
    int t1, t2;
    logic last;
    send(8'heb);
    send(8'hb0);
    send(8'hcc);
    send(8'hb5);
    settle();
    check("led_a", led_a_on_out, 6'h01);
    check("led_b", led_b_on_out, 6'h1f);
    send(8'hbd);
    send(8'h9c);
    settle();
    check("led_a", led_a_on_out, 6'h20);
    check("led_b", led_b_on_out, 6'h00);
    for (int r = 1; r < 3; r++) begin
      send(8'he8 | 8'(r));
      settle();
      t1 = -1;
      t2 = -1;
      last = led_a_on_out[5];
      for (int t = 0; t < 100 && t2 < 0; t++) begin
        @(negedge clk_in);
        if (led_a_on_out[5] !== last && t1 >= 0) t2 = t;
        else if (led_a_on_out[5] !== last) t1 = t;
        last = led_a_on_out[5];
      end
      check("half period", t2 - t1, (r == 1) ? HS : HL);
    end
    led_attr_a_in <= 6'h3a;
    send(8'he8);
    send(8'h9d);
    send(8'hbb);
    settle();
    check("led_a", led_a_on_out, 6'h30);
    send(8'hb8);
    settle();
    check("led_a", led_a_on_out, 6'h20);
    check_cfg();
    $display("led done");
  endtask : test_led
  initial begin
    repeat (100000) @(posedge clk_in);
    err_total++;
    conclude();
  end
  initial begin
    do_reset(1'b0);
    test_commands();
    test_collision();
    test_link();
    test_led();
    do_reset(1'b1);
    conclude();
  end
endmodule : repeater_serial_config_commands_bench
`default_nettype wire
